// file: design/nlr_regs.sv
// link event actions, packet attribute override and translated limit regs
//
// Contract
// - code 0 masks event, code 1 sends MSI
// - codes 2..5 drive INTA..INTD; 6+ reserved
// - MSI only while MSI enable set
// - virtual wire suppressed while legacy disable set
// - act on status set; deassert on clear
// - port A down 5:3, port B up 8:6
// - fields 11:9, 14:12, 17:15; 31:18 zero
// - force relaxed ordering replaces applicable attribute
// - forcing ignores relaxed ordering enable bit
// - bit 1 gives forced relaxed ordering value
// - force no-snoop replaces applicable attribute
// - bit 3 no-snoop value; attribute bits sticky
// - limit in 31:4; above limit fails
// - limits power up ones, survive resets
// - 64-bit BAR0 limit uses next register
// - paired BAR1 limit fully read-write
// - 64-bit BAR2 limit uses next register
// - port A up selector at 2:0
`include "nlr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module nlr_regs (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic pwr_resetn,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [5:0] event_status,
   output nlr_pkg::nlr_irq_msg_t irq_msg,
   input wire nlr_pkg::nlr_pkt_attr_t pkt_in,
   output nlr_pkg::nlr_pkt_attr_t pkt_out,
   input wire nlr_pkg::nlr_xlat_req_t xlat_in,
   output nlr_pkg::nlr_xlat_res_t xlat_out
);

   logic ack_q;
   logic wr_fire;
   logic [31:0] rd_word;
   logic [31:0] readdata_q;
   logic [31:0] action_q;
   logic [3:0] attr_q;
   logic [31:0] lim_q [4];
   logic [31:0] cfg_q;
   logic [5:0] prev_q;
   logic [5:0] pend_set_q;
   logic [5:0] pend_clr_q;
   logic [5:0] rise;
   logic [5:0] fall;
   logic [5:0] vw_sel;
   logic [5:0] served_set;
   logic [5:0] served_clr;
   nlr_pkg::nlr_irq_msg_t msg_d;
   nlr_pkg::nlr_irq_msg_t msg_q;
   nlr_pkg::nlr_pkt_attr_t pkt_q;
   nlr_pkg::nlr_xlat_res_t xlat_q;
   logic bar0_pair;
   logic bar2_pair;

   function automatic logic [2:0] act_of(input logic [31:0] v,
                                         input logic [2:0] i);
      act_of = v[`NLR_SEL_W * i +: `NLR_SEL_W];
   endfunction

   function automatic logic is_vw(input logic [2:0] a);
      is_vw = (a >= `NLR_ACT_INTA) && (a <= `NLR_ACT_INTD);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8 * b +: 8] = wd[8 * b +: 8];
         end
      end
      merge = r;
   endfunction

   // memory space plus 64-bit type turns the next limit into upper bits
   assign bar0_pair = !cfg_q[`NLR_CFG_BAR0_IO] && cfg_q[`NLR_CFG_BAR0_64];
   assign bar2_pair = !cfg_q[`NLR_CFG_BAR2_IO] && cfg_q[`NLR_CFG_BAR2_64];

   // bus slave: fixed one wait state, write lands at the accepting edge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign wr_fire = avs_write && ack_q;

   always_comb begin
      case (avs_address)
         `NLR_OFF_ACTION: rd_word = action_q & `NLR_ACTION_MASK;
         `NLR_OFF_ATTR: rd_word = {28'h000_0000, attr_q};
         `NLR_OFF_LIM0: rd_word = lim_q[0] & `NLR_LIM_FIELD_MASK;
         `NLR_OFF_LIM1:
            rd_word = bar0_pair ? lim_q[1] : lim_q[1] & `NLR_LIM_FIELD_MASK;
         `NLR_OFF_LIM2: rd_word = lim_q[2] & `NLR_LIM_FIELD_MASK;
         `NLR_OFF_LIM3:
            rd_word = bar2_pair ? lim_q[3] : lim_q[3] & `NLR_LIM_FIELD_MASK;
         `NLR_OFF_STATUS:
            rd_word = {14'h0000, event_status, pend_clr_q, pend_set_q};
         `NLR_OFF_CONFIG: rd_word = cfg_q & `NLR_CFG_MASK;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         readdata_q <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         readdata_q <= rd_word;
      end
   end

   assign avs_readdata = readdata_q;

   // selectors for all six link events, port A up in the low field
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         action_q <= 32'h0000_0000;
      end else if (wr_fire && avs_address == `NLR_OFF_ACTION) begin
         action_q <= merge(action_q, avs_writedata, avs_byteenable)
                     & `NLR_ACTION_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_q <= `NLR_CFG_RESET;
      end else if (wr_fire && avs_address == `NLR_OFF_CONFIG) begin
         cfg_q <= merge(cfg_q, avs_writedata, avs_byteenable) & `NLR_CFG_MASK;
      end
   end

   // sticky: only power-on reset clears these, hot resets do not
   always_ff @(posedge sys_clk or negedge pwr_resetn) begin
      if (!pwr_resetn) begin
         attr_q <= `NLR_ATTR_RESET;
      end else if (wr_fire && avs_address == `NLR_OFF_ATTR) begin
         attr_q <= 4'(merge({28'h000_0000, attr_q}, avs_writedata,
                            avs_byteenable));
      end
   end

   // limits ride through every reset except power-on
   always_ff @(posedge sys_clk or negedge pwr_resetn) begin
      if (!pwr_resetn) begin
         // low nibble of the BAR0 and BAR2 limits is reserved, so it powers up clear
         lim_q[0] <= `NLR_LIM_RESET & `NLR_LIM_FIELD_MASK;
         lim_q[1] <= `NLR_LIM_RESET;
         lim_q[2] <= `NLR_LIM_RESET & `NLR_LIM_FIELD_MASK;
         lim_q[3] <= `NLR_LIM_RESET;
      end else if (wr_fire) begin
         case (avs_address)
            `NLR_OFF_LIM0:
               lim_q[0] <= merge(lim_q[0], avs_writedata, avs_byteenable)
                           & `NLR_LIM_FIELD_MASK;
            `NLR_OFF_LIM1:
               lim_q[1] <= merge(lim_q[1], avs_writedata, avs_byteenable)
                           & (bar0_pair ? `NLR_LIM_RESET
                                        : `NLR_LIM_FIELD_MASK);
            `NLR_OFF_LIM2:
               lim_q[2] <= merge(lim_q[2], avs_writedata, avs_byteenable)
                           & `NLR_LIM_FIELD_MASK;
            `NLR_OFF_LIM3:
               lim_q[3] <= merge(lim_q[3], avs_writedata, avs_byteenable)
                           & (bar2_pair ? `NLR_LIM_RESET
                                        : `NLR_LIM_FIELD_MASK);
            default: ;
         endcase
      end
   end

   // event edges; deassert is queued only for virtual-wire selectors
   always_comb begin
      rise = event_status & ~prev_q;
      fall = ~event_status & prev_q;
      for (int i = 0; i < `NLR_NUM_EVENTS; i++) begin
         vw_sel[i] = is_vw(act_of(action_q, 3'(i)));
      end
   end

   // one message per cycle, lowest event first, set before clear
   always_comb begin
      logic found;
      logic [2:0] a;
      found = 1'b0;
      a = `NLR_ACT_MASKED;
      served_set = 6'h00;
      served_clr = 6'h00;
      msg_d = '0;
      for (int i = 0; i < `NLR_NUM_EVENTS; i++) begin
         if (!found && (pend_set_q[i] || pend_clr_q[i])) begin
            found = 1'b1;
            a = act_of(action_q, 3'(i));
            msg_d.event_idx = 3'(i);
            msg_d.wire_sel = 2'(a - `NLR_ACT_INTA);
            if (pend_set_q[i]) begin
               served_set[i] = 1'b1;
               if (a == `NLR_ACT_MSI && cfg_q[`NLR_CFG_MSI_EN]) begin
                  msg_d.valid = 1'b1;
                  msg_d.kind = nlr_pkg::NLR_MSG_MSI;
               end else if (is_vw(a) && !cfg_q[`NLR_CFG_LEG_DIS]) begin
                  msg_d.valid = 1'b1;
                  msg_d.kind = nlr_pkg::NLR_MSG_ASSERT;
               end
            end else begin
               served_clr[i] = 1'b1;
               if (is_vw(a) && !cfg_q[`NLR_CFG_LEG_DIS]) begin
                  msg_d.valid = 1'b1;
                  msg_d.kind = nlr_pkg::NLR_MSG_DEASSERT;
               end
            end
         end
      end
   end

   // a new edge in the serving cycle is kept: set wins over clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 6'h00;
         pend_set_q <= 6'h00;
         pend_clr_q <= 6'h00;
      end else begin
         prev_q <= event_status;
         pend_set_q <= (pend_set_q & ~served_set) | rise;
         pend_clr_q <= (pend_clr_q & ~served_clr) | (fall & vw_sel);
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         msg_q <= '0;
      end else begin
         msg_q <= msg_d;
      end
   end

   assign irq_msg = msg_q;

   // attribute rewrite on packets heading to the opposite side
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pkt_q <= '0;
      end else begin
         pkt_q.valid <= pkt_in.valid;
         pkt_q.ro_applicable <= pkt_in.ro_applicable;
         pkt_q.ns_applicable <= pkt_in.ns_applicable;
         if (!pkt_in.ro_applicable) begin
            pkt_q.ro <= pkt_in.ro;
         end else if (attr_q[`NLR_ATTR_FRO]) begin
            pkt_q.ro <= attr_q[`NLR_ATTR_ROM];
         end else begin
            pkt_q.ro <= pkt_in.ro && cfg_q[`NLR_CFG_ERO];
         end
         if (pkt_in.ns_applicable && attr_q[`NLR_ATTR_FNS]) begin
            pkt_q.ns <= attr_q[`NLR_ATTR_NSM];
         end else begin
            pkt_q.ns <= pkt_in.ns;
         end
      end
   end

   assign pkt_out = pkt_q;

   // limit check; the upper half of a pair is not a window of its own
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         xlat_q <= '0;
      end else begin
         xlat_q.valid <= xlat_in.valid;
         case (xlat_in.bar)
            2'h0: xlat_q.fail <= xlat_in.addr >
               {bar0_pair ? lim_q[1] : 32'h0000_0000, lim_q[0]};
            2'h1: xlat_q.fail <= bar0_pair ||
               xlat_in.addr > {32'h0000_0000, lim_q[1]};
            2'h2: xlat_q.fail <= xlat_in.addr >
               {bar2_pair ? lim_q[3] : 32'h0000_0000, lim_q[2]};
            default: xlat_q.fail <= bar2_pair ||
               xlat_in.addr > {32'h0000_0000, lim_q[3]};
         endcase
      end
   end

   assign xlat_out = xlat_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn || !pwr_resetn);

   // lower events must not rise, and in vw_fall_s must not fall either, else they are served first
   sequence msi_rise_s;
      rise[1] && !rise[0] && pend_set_q == 6'h00 && pend_clr_q == 6'h00 &&
      act_of(action_q, 3'h1) == `NLR_ACT_MSI && cfg_q[`NLR_CFG_MSI_EN];
   endsequence

   sequence vw_fall_s;
      fall[2] && rise[1:0] == 2'h0 && fall[1:0] == 2'h0 &&
      pend_set_q == 6'h00 && pend_clr_q == 6'h00 &&
      is_vw(act_of(action_q, 3'h2)) && !cfg_q[`NLR_CFG_LEG_DIS];
   endsequence

   msi_code_a: assert property (
      msg_q.valid && msg_q.kind == nlr_pkg::NLR_MSG_MSI |->
         act_of(action_q, msg_q.event_idx) == `NLR_ACT_MSI)
      else $error("msi sent for an event not set to msi");

   wire_select_a: assert property (
      msg_q.valid && msg_q.kind != nlr_pkg::NLR_MSG_MSI |->
         act_of(action_q, msg_q.event_idx) ==
         3'(msg_q.wire_sel) + `NLR_ACT_INTA)
      else $error("virtual wire does not match selector");

   msi_enable_a: assert property (
      msg_q.valid && msg_q.kind == nlr_pkg::NLR_MSG_MSI |->
         $past(cfg_q[`NLR_CFG_MSI_EN]))
      else $error("msi sent while msi disabled");

   legacy_gate_a: assert property (
      msg_q.valid && msg_q.kind != nlr_pkg::NLR_MSG_MSI |->
         !$past(cfg_q[`NLR_CFG_LEG_DIS]))
      else $error("virtual wire sent while legacy disabled");

   rise_msi_a: assert property (
      msi_rise_s |=> ##1 (msg_q.valid && msg_q.event_idx == 3'h1 &&
                         msg_q.kind == nlr_pkg::NLR_MSG_MSI))
      else $error("status set did not send msi two cycles later");

   fall_deassert_a: assert property (
      vw_fall_s |=> ##1 (msg_q.valid && msg_q.event_idx == 3'h2 &&
                        msg_q.kind == nlr_pkg::NLR_MSG_DEASSERT))
      else $error("status clear did not send deassert");

   reserved_zero_a: assert property (
      action_q[31:18] == 14'h0000 && lim_q[0][3:0] == 4'h0)
      else $error("reserved bits hold a value");

   force_ro_a: assert property (
      pkt_in.valid && pkt_in.ro_applicable && attr_q[`NLR_ATTR_FRO] |=>
         pkt_out.valid && pkt_out.ro == $past(attr_q[`NLR_ATTR_ROM]))
      else $error("relaxed ordering not forced");

   force_ns_a: assert property (
      pkt_in.valid && pkt_in.ns_applicable && attr_q[`NLR_ATTR_FNS] |=>
         pkt_out.ns == $past(attr_q[`NLR_ATTR_NSM]))
      else $error("no-snoop not forced");

   limit_check_a: assert property (
      xlat_in.valid && xlat_in.bar == 2'h2 && !bar2_pair |=>
         xlat_out.valid &&
         xlat_out.fail == ($past(xlat_in.addr) > {32'h0, $past(lim_q[2])}))
      else $error("bar2 limit check wrong");

   pair_read_a: assert property (
      avs_read && !ack_q && avs_address == `NLR_OFF_LIM1 && !bar0_pair |=>
         !avs_waitrequest && avs_readdata[3:0] == 4'h0)
      else $error("unpaired bar1 limit low bits not zero");

endmodule

`default_nettype wire

// file: design/nlr_consts.svh
// register offsets, field positions, codes and reset values of the link regs
`ifndef NLR_CONSTS_SVH
`define NLR_CONSTS_SVH

`define NLR_ADDR_W 10
`define NLR_OFF_ACTION 10'h210
`define NLR_OFF_ATTR 10'h214
`define NLR_OFF_LIM0 10'h218
`define NLR_OFF_LIM1 10'h21C
`define NLR_OFF_LIM2 10'h220
`define NLR_OFF_LIM3 10'h224
`define NLR_OFF_STATUS 10'h228
`define NLR_OFF_CONFIG 10'h22C

`define NLR_NUM_EVENTS 6
`define NLR_SEL_W 3
`define NLR_ACTION_MASK 32'h0003_FFFF
`define NLR_ACT_MASKED 3'h0
`define NLR_ACT_MSI 3'h1
`define NLR_ACT_INTA 3'h2
`define NLR_ACT_INTD 3'h5

`define NLR_ATTR_FRO 0
`define NLR_ATTR_ROM 1
`define NLR_ATTR_FNS 2
`define NLR_ATTR_NSM 3
`define NLR_ATTR_RESET 4'h0

`define NLR_LIM_RESET 32'hFFFF_FFFF
`define NLR_LIM_FIELD_MASK 32'hFFFF_FFF0

`define NLR_CFG_MSI_EN 0
`define NLR_CFG_LEG_DIS 1
`define NLR_CFG_ERO 2
`define NLR_CFG_BAR0_IO 3
`define NLR_CFG_BAR0_64 4
`define NLR_CFG_BAR2_IO 5
`define NLR_CFG_BAR2_64 6
`define NLR_CFG_MASK 32'h0000_007F
`define NLR_CFG_RESET 32'h0000_0000

`endif

// file: design/nlr_pkg.sv
// types shared by the link event, attribute and limit register block
package nlr_pkg;

   typedef enum logic [1:0] {
      NLR_MSG_MSI,
      NLR_MSG_ASSERT,
      NLR_MSG_DEASSERT
   } nlr_msg_kind_t;

   typedef struct packed {
      logic valid;
      nlr_msg_kind_t kind;
      logic [1:0] wire_sel;
      logic [2:0] event_idx;
   } nlr_irq_msg_t;

   typedef struct packed {
      logic valid;
      logic ro_applicable;
      logic ns_applicable;
      logic ro;
      logic ns;
   } nlr_pkt_attr_t;

   typedef struct packed {
      logic valid;
      logic [1:0] bar;
      logic [63:0] addr;
   } nlr_xlat_req_t;

   typedef struct packed {
      logic valid;
      logic fail;
   } nlr_xlat_res_t;

endpackage

// file: tb/nlr_host_model.sv
// host side receiver of link event interrupt messages
`timescale 1ns/1ps
`default_nettype none

module nlr_host_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire nlr_pkg::nlr_irq_msg_t irq_msg,
   output logic [7:0] msg_cnt,
   output nlr_pkg::nlr_irq_msg_t last_msg,
   output logic [3:0] wire_lvl
);
   // every message counted, so a spurious one is not hidden by a later one
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         msg_cnt <= 8'h00;
         last_msg <= '0;
      end else if (irq_msg.valid) begin
         msg_cnt <= msg_cnt + 8'h01;
         last_msg <= irq_msg;
      end
   end

   // virtual wire levels as the root complex tracks them
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wire_lvl <= 4'h0;
      end else if (irq_msg.valid) begin
         if (irq_msg.kind == nlr_pkg::NLR_MSG_ASSERT) begin
            wire_lvl[irq_msg.wire_sel] <= 1'h1;
         end else if (irq_msg.kind == nlr_pkg::NLR_MSG_DEASSERT) begin
            wire_lvl[irq_msg.wire_sel] <= 1'h0;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/nlr_regs_bench.sv
// self-checking bench for the link event, attribute and limit registers
`include "nlr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module nlr_regs_bench;
   logic sys_clk = 1'h0;
   logic resetn, pwr_resetn, avs_read, avs_write, avs_waitrequest;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable, wire_lvl;
   logic [5:0] event_status;
   logic [7:0] msg_cnt;
   nlr_pkg::nlr_irq_msg_t irq_msg, last_msg;
   nlr_pkg::nlr_pkt_attr_t pkt_in, pkt_out;
   nlr_pkg::nlr_xlat_req_t xlat_in;
   nlr_pkg::nlr_xlat_res_t xlat_out;
   int err_count, n_tests, exp_cnt;
   logic vw;

   nlr_regs DUT (.sys_clk(sys_clk), .resetn(resetn),
      .pwr_resetn(pwr_resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .event_status(event_status), .irq_msg(irq_msg), .pkt_in(pkt_in),
      .pkt_out(pkt_out), .xlat_in(xlat_in), .xlat_out(xlat_out));

   nlr_host_model host (.sys_clk(sys_clk), .resetn(resetn),
      .irq_msg(irq_msg), .msg_cnt(msg_cnt), .last_msg(last_msg),
      .wire_lvl(wire_lvl));

   always #4 sys_clk = ~sys_clk;

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wrap_up;
      $display("checks=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // one access; held until waitrequest is seen low at a rising edge
   task automatic av(input logic w, input logic [9:0] a,
      input logic [31:0] d, input logic [3:0] be, output logic [31:0] r);
      int n;
      logic ok;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 20);
      ok = (avs_waitrequest === 1'h0);
      r = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      if (!ok) begin
         err_count++;
         wrap_up();
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] r;
      av(1'h1, a, d, 4'hF, r);
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] r;
      av(1'h0, a, 32'h0, 4'hF, r);
      chk(r, e);
   endtask

   task automatic pk(input logic [4:0] i, input logic [4:0] e);
      @(posedge sys_clk);
      pkt_in <= i;
      @(posedge sys_clk);
      #1;
      chk(32'(pkt_out), 32'(e));
   endtask

   task automatic xl(input logic [1:0] b, input logic [63:0] a,
      input logic f);
      @(posedge sys_clk);
      xlat_in <= {1'h1, b, a};
      @(posedge sys_clk);
      #1;
      chk(32'(xlat_out), {30'h0, 1'h1, f});
   endtask

   task automatic rpulse(input logic pw);
      @(posedge sys_clk);
      resetn <= 1'h0;
      pwr_resetn <= !pw;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'h1;
      pwr_resetn <= 1'h1;
   endtask

   // settle time covers the three-edge answer at the host plus margin
   task automatic ev(input int e, input logic lvl, input logic m,
      input nlr_pkg::nlr_msg_kind_t k, input logic [1:0] w);
      @(posedge sys_clk);
      event_status[e] <= lvl;
      repeat (6) @(posedge sys_clk);
      if (m) exp_cnt++;
      chk(32'(msg_cnt), exp_cnt);
      if (m) chk(32'({last_msg.kind, last_msg.event_idx}), 32'({k, 3'(e)}));
      if (m && k != nlr_pkg::NLR_MSG_MSI) begin
         chk(32'(last_msg.wire_sel), 32'(w));
         chk(32'(wire_lvl[w]), 32'(lvl));
      end
   endtask

   initial begin
      resetn = 1'h0;
      pwr_resetn = 1'h0;
      avs_address = 10'h0;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      event_status = 6'h0;
      pkt_in = '0;
      xlat_in = '0;
      err_count = 0;
      n_tests = 0;
      exp_cnt = 0;
      repeat (12) @(posedge sys_clk);
      resetn <= 1'h1;
      pwr_resetn <= 1'h1;
      rd(`NLR_OFF_LIM0, 32'hFFFF_FFF0);
      rd(`NLR_OFF_LIM2, 32'hFFFF_FFF0);
      rd(`NLR_OFF_ATTR, 32'h0);
      rd(`NLR_OFF_ACTION, 32'h0);
      wr(10'h3F0, 32'hFFFF_FFFF);
      rd(10'h3F0, 32'h0);
      wr(`NLR_OFF_ACTION, 32'hFFFF_FFFF);
      rd(`NLR_OFF_ACTION, 32'h0003_FFFF);
      av(1'h1, `NLR_OFF_ACTION, 32'h0, 4'h1, q);
      rd(`NLR_OFF_ACTION, 32'h0003_FF00);
      wr(`NLR_OFF_ATTR, 32'hFFFF_FFFF);
      rd(`NLR_OFF_ATTR, 32'h0000_000F);
      wr(`NLR_OFF_ATTR, 32'h5);
      pk(5'h1F, 5'h1C);
      wr(`NLR_OFF_ATTR, 32'hF);
      pk(5'h1C, 5'h1F);
      pk(5'h13, 5'h13);
      wr(`NLR_OFF_ATTR, 32'hA);
      pk(5'h1F, 5'h1D);
      wr(`NLR_OFF_CONFIG, 32'h4);
      pk(5'h1F, 5'h1F);
      wr(`NLR_OFF_CONFIG, 32'h0);
      wr(`NLR_OFF_ATTR, 32'h3);
      pk(5'h18, 5'h1A);
      wr(`NLR_OFF_LIM0, 32'h0000_1005);
      // plain reset must leave sticky and limit state alone
      rpulse(1'h0);
      rd(`NLR_OFF_ATTR, 32'h3);
      rd(`NLR_OFF_ACTION, 32'h0);
      rd(`NLR_OFF_LIM0, 32'h0000_1000);
      xl(2'h0, 64'h1000, 1'h0);
      xl(2'h0, 64'h1001, 1'h1);
      xl(2'h0, 64'h1_0000_0000, 1'h1);
      wr(`NLR_OFF_LIM1, 32'h7);
      rd(`NLR_OFF_LIM1, 32'h0);
      wr(`NLR_OFF_CONFIG, 32'h10);
      wr(`NLR_OFF_LIM1, 32'h3);
      rd(`NLR_OFF_LIM1, 32'h3);
      xl(2'h0, 64'h3_0000_1000, 1'h0);
      xl(2'h0, 64'h3_0000_1001, 1'h1);
      xl(2'h1, 64'h0, 1'h1);
      wr(`NLR_OFF_LIM2, 32'h0000_2000);
      xl(2'h2, 64'h1_0000_2000, 1'h1);
      wr(`NLR_OFF_CONFIG, 32'h40);
      wr(`NLR_OFF_LIM3, 32'h1);
      xl(2'h2, 64'h1_0000_2000, 1'h0);
      xl(2'h2, 64'h1_0000_2010, 1'h1);
      wr(`NLR_OFF_CONFIG, 32'h1);
      for (int c = 0; c < 8; c++) begin
         vw = (c >= 2 && c <= 5);
         wr(`NLR_OFF_ACTION, 32'(c) << (3 * (c % 6)));
         ev(c % 6, 1'h1, c == 1 || vw, vw ? nlr_pkg::NLR_MSG_ASSERT :
            nlr_pkg::NLR_MSG_MSI, 2'(c - 2));
         ev(c % 6, 1'h0, vw, nlr_pkg::NLR_MSG_DEASSERT, 2'(c - 2));
      end
      wr(`NLR_OFF_CONFIG, 32'h0);
      wr(`NLR_OFF_ACTION, 32'h40);
      ev(2, 1'h1, 1'h0, nlr_pkg::NLR_MSG_MSI, 2'h0);
      ev(2, 1'h0, 1'h0, nlr_pkg::NLR_MSG_MSI, 2'h0);
      wr(`NLR_OFF_CONFIG, 32'h3);
      wr(`NLR_OFF_ACTION, 32'h400);
      ev(3, 1'h1, 1'h0, nlr_pkg::NLR_MSG_ASSERT, 2'h0);
      ev(3, 1'h0, 1'h0, nlr_pkg::NLR_MSG_DEASSERT, 2'h0);
      rpulse(1'h1);
      rd(`NLR_OFF_LIM0, 32'hFFFF_FFF0);
      rd(`NLR_OFF_ATTR, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
